//--- common/pss_pkg.sv
// Purpose: constants for the status summary register bank
// Assumes: byte-wide command codes, 8-bit status bytes, 16-bit status word
// Notes: command codes of the word and single byte are chosen locally
package pss_pkg;
    localparam logic [7:0] CMD_STATUS_SINGLE_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
    localparam logic [7:0] STATUS_BYTE_RESET = 8'h00;
    localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;
    // status word bit positions
    localparam int SW_VOUT_BIT = 15;
    localparam int SW_IOUT_BIT = 14;
    localparam int SW_INPUT_BIT = 13;
    localparam int SW_MFR_BIT = 12;
    localparam int SW_POWER_GOOD_SUMMARY_BIT = 11;
    localparam int SB_BUSY_BIT = 7;
    localparam int SB_OFF_BIT = 6;
    localparam int SB_VOUT_OV_BIT = 5;
    localparam int SB_IOUT_OC_BIT = 4;
    localparam int SB_VIN_UV_BIT = 3;
    localparam int SB_TEMP_BIT = 2;
    localparam int SB_CML_BIT = 1;
    localparam int SB_OTHER_BIT = 0;
    // output-voltage status bit positions
    localparam int VS_OV_FAULT_BIT = 7;
    localparam int VS_UV_FAULT_BIT = 4;
    localparam int VS_MAX_WARN_BIT = 3;
    // output-current status bit positions
    localparam int CS_OC_FAULT_BIT = 7;
    localparam int CS_OC_WARN_BIT = 5;
    localparam int FLAG_COUNT = 9;
    // flag indices into the latch bank
    localparam int FL_VOUT_OV = 0;
    localparam int FL_VOUT_UV = 1;
    localparam int FL_OUTPUT_LIMIT_EXCEEDED_WARNING = 2;
    localparam int FL_IOUT_OCF = 3;
    localparam int FL_IOUT_OCW = 4;
    localparam int FL_INPUT = 5;
    localparam int FL_MFR = 6;
    localparam int FL_TEMP = 7;
    localparam int FL_CML = 8;
endpackage

//--- rtl/pss_flag.sv
// Purpose: one sticky status flag
// Assumes: set and clear are single-cycle pulses on the core clock
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
module pss_flag
    import pss_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_flag
);
    typedef struct packed {
        logic flag;
    } pss_flag_state_type;
    pss_flag_state_type state_reg, state_next;
    always_comb
    begin
        state_next = state_reg;
        if (i_set)
            state_next.flag = 1'b1;
        else if (i_clear)
            state_next.flag = 1'b0;
    end
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end
    assign o_flag = state_reg.flag;
endmodule

//--- rtl/pss_status_regs.sv
// Purpose: read-only status word and status bytes for a power controller
// Assumes: fault events are one-cycle pulses from core-clock logic; power-ready pin is asynchronous
// Notes: reads never disturb flags; only i_fault_clear or i_nrst clears them
`timescale 1ns/1ps
module pss_status_regs
    import pss_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_vout_ov_fault,
    input wire logic i_vout_uv_fault,
    input wire logic i_output_limit_exceeded_warning,
    input wire logic i_iout_oc_fault,
    input wire logic i_iout_oc_warning,
    input wire logic i_input_fault,
    input wire logic i_input_uv_fault,
    input wire logic i_mfr_fault,
    input wire logic i_temp_fault,
    input wire logic i_cml_fault,
    input wire logic i_other_fault,
    input wire logic i_output_off,
    input wire logic i_power_ready_pin,
    input wire logic i_fault_clear,
    input wire logic i_rd_req,
    input wire logic [7:0] i_rd_cmd,
    output logic o_rd_valid,
    output logic o_rd_is_word,
    output logic o_rd_unmapped,
    output logic [15:0] o_rd_data,
    output logic o_host_alert_line
);
    typedef struct packed {
        logic rd_valid;
        logic rd_is_word;
        logic rd_unmapped;
        logic [15:0] rd_data;
        logic alert;
        logic vin_uv;
        logic other;
    } pss_top_state_type;
    pss_top_state_type state_reg, state_next;
    logic [FLAG_COUNT-1:0] flag_set;
    logic [FLAG_COUNT-1:0] flag_q;
    logic power_ready_sync;
    logic [7:0] voltage_status;
    logic [7:0] current_status;
    logic [7:0] single_status;
    logic [15:0] status_word;

    pss_sync u_ready_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_async(i_power_ready_pin),
        .o_sync(power_ready_sync)
    );

    always_comb
    begin
        flag_set = '0;
        flag_set[FL_VOUT_OV] = i_vout_ov_fault;
        flag_set[FL_VOUT_UV] = i_vout_uv_fault;
        flag_set[FL_OUTPUT_LIMIT_EXCEEDED_WARNING] = i_output_limit_exceeded_warning;
        flag_set[FL_IOUT_OCF] = i_iout_oc_fault;
        flag_set[FL_IOUT_OCW] = i_iout_oc_warning;
        flag_set[FL_INPUT] = i_input_fault | i_input_uv_fault;
        flag_set[FL_MFR] = i_mfr_fault;
        flag_set[FL_TEMP] = i_temp_fault;
        flag_set[FL_CML] = i_cml_fault;
    end

    // one sticky cell per detailed flag; only the explicit clear or i_nrst resets them
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++)
        begin : g_flag
            pss_flag u_flag (
                .i_core_clk(i_core_clk),
                .i_nrst(i_nrst),
                .i_set(flag_set[gi]),
                .i_clear(i_fault_clear),
                .o_flag(flag_q[gi])
            );
        end
    endgenerate

    always_comb
    begin
        voltage_status = STATUS_BYTE_RESET;
        voltage_status[VS_OV_FAULT_BIT] = flag_q[FL_VOUT_OV];
        voltage_status[VS_UV_FAULT_BIT] = flag_q[FL_VOUT_UV];
        voltage_status[VS_MAX_WARN_BIT] = flag_q[FL_OUTPUT_LIMIT_EXCEEDED_WARNING];
        current_status = STATUS_BYTE_RESET;
        current_status[CS_OC_FAULT_BIT] = flag_q[FL_IOUT_OCF];
        current_status[CS_OC_WARN_BIT] = flag_q[FL_IOUT_OCW];
        single_status = STATUS_BYTE_RESET;
        single_status[SB_BUSY_BIT] = 1'b0;
        single_status[SB_OFF_BIT] = i_output_off;
        single_status[SB_VOUT_OV_BIT] = flag_q[FL_VOUT_OV];
        single_status[SB_IOUT_OC_BIT] = flag_q[FL_IOUT_OCF];
        single_status[SB_VIN_UV_BIT] = state_reg.vin_uv;
        single_status[SB_TEMP_BIT] = flag_q[FL_TEMP];
        single_status[SB_CML_BIT] = flag_q[FL_CML];
        single_status[SB_OTHER_BIT] = state_reg.other;
        status_word = STATUS_WORD_RESET;
        status_word[SW_VOUT_BIT] = |voltage_status;
        status_word[SW_IOUT_BIT] = |current_status;
        status_word[SW_INPUT_BIT] = flag_q[FL_INPUT];
        status_word[SW_MFR_BIT] = flag_q[FL_MFR];
        status_word[SW_POWER_GOOD_SUMMARY_BIT] = ~power_ready_sync;
        status_word[7:0] = single_status;
    end

    always_comb
    begin
        state_next = state_reg;
        // set wins over clear for the locally held byte flags
        if (i_input_uv_fault)
            state_next.vin_uv = 1'b1;
        else if (i_fault_clear)
            state_next.vin_uv = 1'b0;
        if (i_other_fault || i_iout_oc_warning)
            state_next.other = 1'b1;
        else if (i_fault_clear)
            state_next.other = 1'b0;
        // input undervoltage alone never raises the alert
        if (i_vout_ov_fault || i_vout_uv_fault || i_output_limit_exceeded_warning || i_iout_oc_fault
            || i_iout_oc_warning || i_input_fault || i_mfr_fault || i_temp_fault || i_cml_fault
            || i_other_fault)
            state_next.alert = 1'b1;
        else if (i_fault_clear)
            state_next.alert = 1'b0;
        // registered read answer one cycle after the request; flags untouched
        state_next.rd_valid = i_rd_req;
        state_next.rd_is_word = 1'b0;
        state_next.rd_unmapped = 1'b0;
        state_next.rd_data = state_reg.rd_data;
        if (i_rd_req)
        begin
            unique case (i_rd_cmd)
                CMD_SUMMARY_STATUS_WORD:
                begin
                    state_next.rd_data = status_word;
                    state_next.rd_is_word = 1'b1;
                end
                CMD_STATUS_SINGLE_BYTE:
                    state_next.rd_data = {8'h00, single_status};
                CMD_OUTPUT_VOLTAGE_STATUS:
                    state_next.rd_data = {8'h00, voltage_status};
                CMD_OUTPUT_CURRENT_STATUS:
                    state_next.rd_data = {8'h00, current_status};
                default:
                begin
                    state_next.rd_data = 16'h0000;
                    state_next.rd_unmapped = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign o_rd_valid = state_reg.rd_valid;
    assign o_rd_is_word = state_reg.rd_is_word;
    assign o_rd_unmapped = state_reg.rd_unmapped;
    assign o_rd_data = state_reg.rd_data;
    assign o_host_alert_line = state_reg.alert;
endmodule

//--- rtl/pss_sync.sv
// Purpose: two-flop synchroniser for a pin level
// Assumes: level input from another domain
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pss_sync
    import pss_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } pss_sync_state_type;
    pss_sync_state_type state_reg, state_next;
    always_comb
    begin
        state_next.meta = i_async;
        state_next.sync = state_reg.meta;
    end
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end
    assign o_sync = state_reg.sync;
endmodule

//--- verif/pss_host_model.sv
// Purpose: host side issuing status reads
// Assumes: one read in flight at a time
// Notes: idle command lines show the inverse of the last code
`timescale 1ns/1ps
module pss_host_model
    import pss_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data,
    output logic o_rd_req,
    output logic [7:0] o_rd_cmd
);
    initial
    begin
        o_rd_req = 1'b0;
        o_rd_cmd = 8'h00;
    end
    // no answer returns unknowns so a caller can never match by luck
    task automatic read(input logic [7:0] cmd, output logic [15:0] data);
        @(posedge i_core_clk);
        o_rd_req <= 1'b1;
        o_rd_cmd <= cmd;
        @(posedge i_core_clk);
        o_rd_req <= 1'b0;
        o_rd_cmd <= ~cmd;
        #1;
        data = i_rd_valid ? i_rd_data : 16'hxxxx;
    endtask
endmodule

//--- verif/pss_status_regs_chk.sv
// Purpose: port-level checks of the status register bank
// Assumes: one clock, async active-low reset
// Notes: bound to every pss_status_regs instance
`timescale 1ns/1ps
module pss_status_regs_chk
    import pss_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_vout_ov_fault,
    input wire logic i_iout_oc_fault,
    input wire logic i_iout_oc_warning,
    input wire logic i_mfr_fault,
    input wire logic i_power_ready_pin,
    input wire logic i_rd_req,
    input wire logic [7:0] i_rd_cmd,
    input wire logic o_rd_valid,
    input wire logic o_rd_is_word,
    input wire logic o_rd_unmapped,
    input wire logic [15:0] o_rd_data,
    input wire logic o_host_alert_line
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    AST_ANSWER: assert property (i_rd_req |=> o_rd_valid)
        else $error("read not answered");
    AST_HOLD: assert property (!i_rd_req |=> !o_rd_valid && $stable(o_rd_data))
        else $error("answer moved without request");
    AST_UNMAPPED: assert property (i_rd_req && i_rd_cmd > CMD_OUTPUT_CURRENT_STATUS
        |=> o_rd_unmapped && o_rd_data == 16'h0000)
        else $error("unknown command answered");
    AST_VOUT_RSV: assert property (i_rd_req && i_rd_cmd == CMD_OUTPUT_VOLTAGE_STATUS
        |=> !o_rd_is_word && (o_rd_data & 16'hff67) == 16'h0000)
        else $error("voltage byte reserved bits set");
    AST_IOUT_RSV: assert property (i_rd_req && i_rd_cmd == CMD_OUTPUT_CURRENT_STATUS
        |=> !o_rd_is_word && (o_rd_data & 16'hff5f) == 16'h0000)
        else $error("current byte reserved bits set");
    AST_WORD_RSV: assert property (i_rd_req && i_rd_cmd == CMD_SUMMARY_STATUS_WORD
        |=> o_rd_is_word && o_rd_data[10:7] == 4'h0)
        else $error("word reserved or busy bit set");
    AST_POWER_GOOD_SUMMARY: assert property ($stable(i_power_ready_pin)[*4] ##0 (i_rd_req && i_rd_cmd == CMD_SUMMARY_STATUS_WORD)
        |=> o_rd_data[SW_POWER_GOOD_SUMMARY_BIT] == !$past(i_power_ready_pin))
        else $error("power good bit wrong");
    AST_ALERT: assert property (i_vout_ov_fault || i_iout_oc_fault || i_mfr_fault |=> o_host_alert_line)
        else $error("alert not raised");
    AST_VOV: assert property (i_vout_ov_fault ##2 (i_rd_req && i_rd_cmd == CMD_OUTPUT_VOLTAGE_STATUS)
        |=> o_rd_data[VS_OV_FAULT_BIT])
        else $error("overvoltage flag not latched");
    AST_IOUT_SUM: assert property (i_iout_oc_warning ##2 (i_rd_req && i_rd_cmd == CMD_SUMMARY_STATUS_WORD)
        |=> o_rd_data[SW_IOUT_BIT])
        else $error("current summary not set");
endmodule
bind pss_status_regs pss_status_regs_chk u_chk (.*);

//--- verif/tb_pmbus_status_summary_regs.sv
// Purpose: self-checking bench for the status register bank
// Assumes: 250 MHz core clock, host model issues all reads
// Notes: fault inputs are pulsed for one cycle each
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_pmbus_status_summary_regs
    import pss_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [10:0] ev = 11'h000;
    logic off = 1'b0;
    logic pin = 1'b1;
    logic clr = 1'b0;
    logic req, valid, word, unm, alert;
    logic [7:0] cmd;
    logic [15:0] data;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    pss_status_regs dut (.i_core_clk(clk), .i_nrst(nrst), .i_vout_ov_fault(ev[0]), .i_vout_uv_fault(ev[1]),
        .i_output_limit_exceeded_warning(ev[2]), .i_iout_oc_fault(ev[3]), .i_iout_oc_warning(ev[4]),
        .i_input_fault(ev[5]), .i_input_uv_fault(ev[6]), .i_mfr_fault(ev[7]), .i_temp_fault(ev[8]),
        .i_cml_fault(ev[9]), .i_other_fault(ev[10]), .i_output_off(off), .i_power_ready_pin(pin),
        .i_fault_clear(clr), .i_rd_req(req), .i_rd_cmd(cmd), .o_rd_valid(valid), .o_rd_is_word(word),
        .o_rd_unmapped(unm), .o_rd_data(data), .o_host_alert_line(alert));
    pss_host_model host (.i_core_clk(clk), .i_rd_valid(valid), .i_rd_data(data), .o_rd_req(req), .o_rd_cmd(cmd));
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 11'h000;
    endtask
    task automatic clear_all;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        host.read(c, d);
        `CHK("read data", e, d & m)
    endtask
    task automatic t_reset;
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, STATUS_WORD_RESET);
        `CHK("word answer", 1'h1, word)
        rd(CMD_STATUS_SINGLE_BYTE, 16'hffff, 16'h0000);
        rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'hffff, 16'h0000);
        `CHK("word answer", 1'h0, word)
        rd(CMD_OUTPUT_CURRENT_STATUS, 16'hffff, 16'h0000);
        `CHK("unmapped", 1'h0, unm)
        rd(8'h80, 16'hffff, 16'h0000);
        `CHK("unmapped", 1'h1, unm)
        $display("reset test done");
    endtask
    task automatic t_vout;
        pulse(0);
        rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'hffff, 16'h0080);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h8020);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h8020);
        `CHK("alert", 1'b1, alert)
        pulse(1);
        pulse(2);
        rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'hffff, 16'h0098);
        clear_all();
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h0000);
        `CHK("alert", 1'b0, alert)
        pulse(2);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hff00, 16'h8000);
        clear_all();
        $display("output voltage test done");
    endtask
    task automatic t_iout;
        pulse(3);
        rd(CMD_OUTPUT_CURRENT_STATUS, 16'hffff, 16'h0080);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h4010);
        pulse(4);
        rd(CMD_OUTPUT_CURRENT_STATUS, 16'hffff, 16'h00a0);
        clear_all();
        pulse(4);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hff00, 16'h4000);
        clear_all();
        $display("output current test done");
    endtask
    task automatic t_input;
        pulse(6);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h2008);
        `CHK("alert", 1'b0, alert)
        pulse(7);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hff00, 16'h3000);
        `CHK("alert", 1'b1, alert)
        clear_all();
        pulse(5);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hff00, 16'h2000);
        clear_all();
        for (int i = 8; i < 11; i++)
        begin
            pulse(i);
            rd(CMD_STATUS_SINGLE_BYTE, 16'hffff, 16'h0001 << (10 - i));
            clear_all();
        end
        $display("input and byte test done");
    endtask
    task automatic t_power_good_summary;
        @(posedge clk);
        pin <= 1'b0;
        off <= 1'b1;
        // pin passes a two-flop synchroniser first
        repeat (3) @(posedge clk);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h0840);
        @(posedge clk);
        pin <= 1'b1;
        off <= 1'b0;
        repeat (3) @(posedge clk);
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, 16'h0000);
        $display("power good test done");
    endtask
    // event and clear land on the same edge: the event must survive
    task automatic t_race;
        @(posedge clk);
        ev[0] <= 1'h1;
        clr <= 1'h1;
        @(posedge clk);
        ev <= 11'h000;
        clr <= 1'h0;
        rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'hffff, 16'h0080);
        `CHK("alert", 1'h1, alert)
        clear_all();
        $display("set over clear test done");
    endtask
    // latched flags and alert must be gone after a mid-run reset
    task automatic t_rst;
        pulse(3);
        rd(CMD_OUTPUT_CURRENT_STATUS, 16'hffff, 16'h0080);
        @(posedge clk);
        nrst <= 1'h0;
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        `CHK("alert", 1'h0, alert)
        rd(CMD_OUTPUT_CURRENT_STATUS, 16'hffff, {8'h00, STATUS_BYTE_RESET});
        rd(CMD_SUMMARY_STATUS_WORD, 16'hffff, STATUS_WORD_RESET);
        $display("mid-run reset test done");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_vout();
        t_iout();
        t_input();
        t_power_good_summary();
        t_race();
        t_rst();
        stop_test();
    end
    // whole run needs about 130 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_total++;
            stop_test();
        end
    end
endmodule
